// ===== hw/tcv_pkg.sv
/*
  Constants, register map and carrier types for the registered bus
  transceiver. Assumes a single 40 MHz clock domain and an Avalon-MM
  slave with 32-bit data and byte addresses.
*/

package tcv_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int BUS_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int LOG_DEPTH = 4;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CAPTURE = 5'h04;
  localparam logic [4:0] OFF_STORE = 5'h08;
  localparam logic [4:0] OFF_PINS = 5'h0c;
  localparam logic [4:0] OFF_LOG = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CAP_A_LSB = 0;
  localparam int CAP_B_LSB = 2;
  localparam int STAT_LOG_BIT = 0;
  localparam int STAT_OVF_BIT = 1;

  // Control register, one bit per byte lane in every field
  typedef struct packed {
    logic [1:0] b_to_a_source_select;
    logic [1:0] a_to_b_source_select;
    logic [1:0] b_to_a_drive_enable_low;
    logic [1:0] a_to_b_drive_enable;
  } tcv_ctrl_type;

  // Reset leaves both ports isolated and selecting live data
  localparam tcv_ctrl_type CTRL_RESET = 8'h0c;

  // One captured snapshot of both pin groups
  typedef struct packed {
    logic [15:0] b_pins;
    logic [15:0] a_pins;
  } tcv_snap_type;

endpackage

// ===== hw/tcv_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tcv_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] count_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count_q != (PW+1)'(DEPTH);
  assign out_valid = count_q != '0;
  assign out_data = mem_q[rd_q];

  // Pointers wrap naturally only for a power-of-two depth
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

endmodule

`default_nettype wire

// ===== hw/tcv_lane.sv
/*
  One byte lane: capture-clock edge detection and the two storage
  registers. Assumes capture clocks are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tcv_lane (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic a_capture_clock,
  input wire logic b_capture_clock,
  input wire logic a_force,
  input wire logic b_force,
  output logic a_load,
  output logic b_load,
  output logic [7:0] a_store_q,
  output logic [7:0] a_store_d,
  output logic [7:0] b_store_q,
  output logic [7:0] b_store_d
);

  logic a_prev_q;
  logic b_prev_q;

  // Edges are never gated by enables or selects
  assign a_load = (a_capture_clock & ~a_prev_q) | a_force;
  assign b_load = (b_capture_clock & ~b_prev_q) | b_force;
  assign a_store_d = a_load ? a_in : a_store_q;
  assign b_store_d = b_load ? b_in : b_store_q;

  // Reset high so a clock held high at release is no false edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      a_prev_q <= 1'b1;
      b_prev_q <= 1'b1;
    end else begin
      a_prev_q <= a_capture_clock;
      b_prev_q <= b_capture_clock;
    end
  end

  // Data storage deliberately has no reset
  always_ff @(posedge mclk) begin
    a_store_q <= a_store_d;
    b_store_q <= b_store_d;
  end

endmodule

`default_nettype wire

// ===== hw/tcv_top.sv
/*
  Registered 16-bit bus transceiver with two byte lanes, Avalon-MM
  register access and a four-entry capture log.
  Assumes all inputs synchronous to mclk; the bench resolves the A and B
  wires from the out and oe signals.
*/
`timescale 1ns/1ps
`default_nettype none

module tcv_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] a_in,
  output logic [15:0] a_out,
  output logic [1:0] a_oe,
  input wire logic [15:0] b_in,
  output logic [15:0] b_out,
  output logic [1:0] b_oe,
  input wire logic [1:0] a_capture_clock,
  input wire logic [1:0] b_capture_clock
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] lane_mux(
    input logic stored_sel,
    input logic [7:0] stored,
    input logic [7:0] live
  );
    return stored_sel ? stored : live;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  tcv_pkg::tcv_ctrl_type ctrl_q;
  tcv_pkg::tcv_ctrl_type ctrl_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic ovf_q;
  logic ovf_d;
  logic [15:0] a_out_q;
  logic [15:0] b_out_q;
  logic [1:0] a_oe_q;
  logic [1:0] b_oe_q;

  logic [15:0] a_store_q;
  logic [15:0] a_store_d;
  logic [15:0] b_store_q;
  logic [15:0] b_store_d;
  logic [1:0] a_load;
  logic [1:0] b_load;
  logic [15:0] a_out_d;
  logic [15:0] b_out_d;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire sel_ctrl = avs_address == tcv_pkg::OFF_CTRL;
  wire sel_cap = avs_address == tcv_pkg::OFF_CAPTURE;
  wire sel_store = avs_address == tcv_pkg::OFF_STORE;
  wire sel_pins = avs_address == tcv_pkg::OFF_PINS;
  wire sel_log = avs_address == tcv_pkg::OFF_LOG;
  wire sel_stat = avs_address == tcv_pkg::OFF_STATUS;
  wire req = avs_read | avs_write;
  // The edge at which the master sees waitrequest low
  wire done = req & ~wait_q;
  wire wr_done = done & avs_write & avs_byteenable[0];

  wire [1:0] sw_cap_a = wr_done & sel_cap ?
    avs_writedata[tcv_pkg::CAP_A_LSB +: 2] : 2'h0;
  wire [1:0] sw_cap_b = wr_done & sel_cap ?
    avs_writedata[tcv_pkg::CAP_B_LSB +: 2] : 2'h0;
  wire cap_any = |{avs_writedata[tcv_pkg::CAP_A_LSB +: 2],
    avs_writedata[tcv_pkg::CAP_B_LSB +: 2]};
  wire ovf_clear = wr_done & sel_stat &
    avs_writedata[tcv_pkg::STAT_OVF_BIT];

  // ------------------------------------------------------------------
  // Capture log
  // ------------------------------------------------------------------
  wire log_push = |{a_load, b_load};
  wire log_in_ready;
  wire log_valid;
  wire [31:0] log_data;
  wire log_pop = done & avs_read & sel_log;
  tcv_pkg::tcv_snap_type snap;
  assign snap.a_pins = a_in;
  assign snap.b_pins = b_in;

  tcv_fifo #(
    .WIDTH(tcv_pkg::DATA_W),
    .DEPTH(tcv_pkg::LOG_DEPTH)
  ) u_log (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(log_push),
    .in_ready(log_in_ready),
    .in_data(snap),
    .out_valid(log_valid),
    .out_ready(log_pop),
    .out_data(log_data)
  );

  // Reading an empty log or commanding a capture into a full log stalls
  // the master instead of losing data.
  wire blocked = (avs_read & sel_log & ~log_valid) |
    (avs_write & sel_cap & avs_byteenable[0] & cap_any & ~log_in_ready);

  assign wait_d = done ? 1'b1 : ~(req & ~blocked);

  wire [31:0] rd_mux =
    sel_ctrl ? {24'h0, ctrl_q} :
    sel_store ? {b_store_q, a_store_q} :
    sel_pins ? {b_in, a_in} :
    sel_log ? log_data :
    sel_stat ? {30'h0, ovf_q, log_valid} :
    32'h0;

  assign ctrl_d = wr_done & sel_ctrl ?
    tcv_pkg::tcv_ctrl_type'(avs_writedata[7:0]) : ctrl_q;

  // A push refused by a full log sets overflow; set beats clear
  assign ovf_d = (log_push & ~log_in_ready) | (ovf_q & ~ovf_clear);

  // ------------------------------------------------------------------
  // Byte lanes
  // ------------------------------------------------------------------
  for (genvar i = 0; i < tcv_pkg::LANES; i++) begin : g_lane
    tcv_lane u_lane (
      .mclk(mclk),
      .arst_n(arst_n),
      .a_in(a_in[8*i +: 8]),
      .b_in(b_in[8*i +: 8]),
      .a_capture_clock(a_capture_clock[i]),
      .b_capture_clock(b_capture_clock[i]),
      .a_force(sw_cap_a[i]),
      .b_force(sw_cap_b[i]),
      .a_load(a_load[i]),
      .b_load(b_load[i]),
      .a_store_q(a_store_q[8*i +: 8]),
      .a_store_d(a_store_d[8*i +: 8]),
      .b_store_q(b_store_q[8*i +: 8]),
      .b_store_d(b_store_d[8*i +: 8])
    );
    // Next stored value feeds the pins so a capture shows at once
    assign b_out_d[8*i +: 8] = lane_mux(
      ctrl_q.a_to_b_source_select[i], a_store_d[8*i +: 8],
      a_in[8*i +: 8]);
    assign a_out_d[8*i +: 8] = lane_mux(
      ctrl_q.b_to_a_source_select[i], b_store_d[8*i +: 8],
      b_in[8*i +: 8]);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= tcv_pkg::CTRL_RESET;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      ovf_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      wait_q <= wait_d;
      rdata_q <= rd_mux;
      ovf_q <= ovf_d;
    end
  end

  // With both live directions on, each output follows the other port's input one
  // cycle later: this loop holds the bus but is not storage.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      a_out_q <= 16'h0;
      b_out_q <= 16'h0;
      a_oe_q <= 2'h0;
      b_oe_q <= 2'h0;
    end else begin
      a_out_q <= a_out_d;
      b_out_q <= b_out_d;
      a_oe_q <= ~ctrl_q.b_to_a_drive_enable_low;
      b_oe_q <= ctrl_q.a_to_b_drive_enable;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign a_out = a_out_q;
  assign b_out = b_out_q;
  assign a_oe = a_oe_q;
  assign b_oe = b_oe_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  b_drive_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1 |=> b_oe_q == $past(ctrl_q.a_to_b_drive_enable))
    else $error("B drive enable does not follow control");

  a_drive_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1 |=> a_oe_q == ~$past(ctrl_q.b_to_a_drive_enable_low))
    else $error("A drive enable does not follow control");

  ab_live_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_q.a_to_b_drive_enable[0] & ~ctrl_q.a_to_b_source_select[0])
    |=> b_out_q[7:0] == $past(a_in[7:0]))
    else $error("Live A data not passed to B");

  ab_live_hi_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_q.a_to_b_drive_enable[1] & ~ctrl_q.a_to_b_source_select[1])
    |=> b_out_q[15:8] == $past(a_in[15:8]))
    else $error("Live A data not passed to upper B byte");

  ab_stored_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_q.a_to_b_drive_enable[1] & ctrl_q.a_to_b_source_select[1])
    |=> b_out_q[15:8] == a_store_q[15:8])
    else $error("Stored A data not shown on B");

  ab_stored_lo_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_q.a_to_b_drive_enable[0] & ctrl_q.a_to_b_source_select[0])
    |=> b_out_q[7:0] == a_store_q[7:0])
    else $error("Stored A data not shown on lower B byte");

  ba_live_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (~ctrl_q.b_to_a_drive_enable_low[1] & ~ctrl_q.b_to_a_source_select[1])
    |=> a_out_q[15:8] == $past(b_in[15:8]))
    else $error("Live B data not passed to A");

  ba_live_lo_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (~ctrl_q.b_to_a_drive_enable_low[0] & ~ctrl_q.b_to_a_source_select[0])
    |=> a_out_q[7:0] == $past(b_in[7:0]))
    else $error("Live B data not passed to lower A byte");

  ba_stored_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (~ctrl_q.b_to_a_drive_enable_low[0] & ctrl_q.b_to_a_source_select[0])
    |=> a_out_q[7:0] == b_store_q[7:0])
    else $error("Stored B data not shown on A");

  ba_stored_hi_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (~ctrl_q.b_to_a_drive_enable_low[1] & ctrl_q.b_to_a_source_select[1])
    |=> a_out_q[15:8] == b_store_q[15:8])
    else $error("Stored B data not shown on upper A byte");

  a_capture_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(a_capture_clock[0]) |=> a_store_q[7:0] == $past(a_in[7:0]))
    else $error("A capture edge did not load A pins");

  a_capture_hi_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(a_capture_clock[1]) |=> a_store_q[15:8] == $past(a_in[15:8]))
    else $error("A capture edge did not load upper A pins");

  b_capture_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(b_capture_clock[1]) |=> b_store_q[15:8] == $past(b_in[15:8]))
    else $error("B capture edge did not load B pins");

  b_capture_lo_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(b_capture_clock[0]) |=> b_store_q[7:0] == $past(b_in[7:0]))
    else $error("B capture edge did not load lower B pins");

  store_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!a_load[0] && !b_load[0]) |=>
    $stable(a_store_q[7:0]) && $stable(b_store_q[7:0]))
    else $error("Storage changed without a capture");

  store_hold_hi_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!a_load[1] && !b_load[1]) |=>
    $stable(a_store_q[15:8]) && $stable(b_store_q[15:8]))
    else $error("Upper storage changed without a capture");

  cross_stored_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl_q == tcv_pkg::tcv_ctrl_type'(8'hf3)) |=>
    b_out_q == a_store_q && a_out_q == b_store_q &&
    a_oe_q == 2'h3 && b_oe_q == 2'h3)
    else $error("Stored data not crossed both ways");

  // ------------------------------------------------------------------
  // Bus and log assertions
  // ------------------------------------------------------------------
  // A second low cycle would let the master count one transfer twice
  wait_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !wait_q |=> wait_q)
    else $error("Waitrequest low for more than one cycle");

  ovf_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (log_push && !log_in_ready) |=> ovf_q)
    else $error("Refused capture did not set overflow");

  ovf_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ovf_q && !ovf_clear) |=> ovf_q)
    else $error("Overflow dropped without a clear");

  ovf_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ovf_clear && !log_push) |=> !ovf_q)
    else $error("Overflow not cleared by software");

  pop_nonempty_a: assert property (@(posedge mclk) disable iff (!arst_n)
    log_pop |-> log_valid)
    else $error("Log popped while empty");

  soft_cap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_done && sel_cap && avs_writedata[tcv_pkg::CAP_A_LSB])
    |=> a_store_q[7:0] == $past(a_in[7:0]))
    else $error("Software capture did not load A pins");

  ctrl_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_done && sel_ctrl) |=> ctrl_q == $past(avs_writedata[7:0]))
    else $error("Control write did not land");

  ctrl_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (avs_read && sel_ctrl) |=> rdata_q == {24'h0, $past(ctrl_q)})
    else $error("Control read data wrong");

  store_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (avs_read && sel_store) |=>
    rdata_q == {$past(b_store_q), $past(a_store_q)})
    else $error("Storage read data wrong");

  status_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (avs_read && sel_stat) |=>
    rdata_q == {30'h0, $past(ovf_q), $past(log_valid)})
    else $error("Status read data wrong");

  unmapped_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (avs_read && !(sel_ctrl || sel_cap || sel_store || sel_pins ||
    sel_log || sel_stat)) |=> rdata_q == 32'h0)
    else $error("Unmapped read not zero");

endmodule

`default_nettype wire

// ===== tb/tcv_bus_model.sv
/*
  Far-side model: the parallel A and B buses outside the transceiver.
  Assumes the bench chooses per byte lane what each bus drives.
*/
`timescale 1ns/1ps
`default_nettype none

module tcv_bus_model (
  input wire logic mclk,
  input wire logic [15:0] a_out,
  input wire logic [1:0] a_oe,
  input wire logic [15:0] b_out,
  input wire logic [1:0] b_oe,
  input wire logic [15:0] a_drv,
  input wire logic [1:0] a_drv_en,
  input wire logic [15:0] b_drv,
  input wire logic [1:0] b_drv_en,
  output logic [15:0] a_in,
  output logic [15:0] b_in
);
  logic [15:0] a_last_q;
  logic [15:0] b_last_q;

  // A floating lane shows the inverse of its last level, so stale data
  // can never pass for a held value
  always_ff @(posedge mclk) begin
    a_last_q <= a_in;
    b_last_q <= b_in;
  end

  // Two drivers on one lane give an unknown level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (a_oe[i] && a_drv_en[i]) begin
        a_in[i*8 +: 8] = 8'hxx;
      end else if (a_oe[i]) begin
        a_in[i*8 +: 8] = a_out[i*8 +: 8];
      end else if (a_drv_en[i]) begin
        a_in[i*8 +: 8] = a_drv[i*8 +: 8];
      end else begin
        a_in[i*8 +: 8] = ~a_last_q[i*8 +: 8];
      end
      if (b_oe[i] && b_drv_en[i]) begin
        b_in[i*8 +: 8] = 8'hxx;
      end else if (b_oe[i]) begin
        b_in[i*8 +: 8] = b_out[i*8 +: 8];
      end else if (b_drv_en[i]) begin
        b_in[i*8 +: 8] = b_drv[i*8 +: 8];
      end else begin
        b_in[i*8 +: 8] = ~b_last_q[i*8 +: 8];
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/registered_bus_transceiver_tb.sv
/*
  Self-checking bench for the registered bus transceiver.
  Assumes the far-side bus model and the Avalon-MM register map.
*/
`timescale 1ns/1ps
`default_nettype none

module registered_bus_transceiver_tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] a_v;
    logic [15:0] b_v;
    logic [1:0] a_oe;
    logic [1:0] b_oe;
  } tcv_row_type;

  localparam tcv_row_type ROWS [4] = '{
    '{8'h0c, 16'ha5c3, 16'h3c5a, 2'h0, 2'h0},
    '{8'h0f, 16'ha5c3, 16'h3c5a, 2'h0, 2'h3},
    '{8'h00, 16'h0ff0, 16'hf00f, 2'h3, 2'h0},
    '{8'h05, 16'h1e2d, 16'h4b78, 2'h2, 2'h1}};

  logic mclk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] a_in, a_out, b_in, b_out, a_drv, b_drv;
  logic [1:0] a_oe, b_oe, a_cap, b_cap, a_drv_en, b_drv_en;
  int error_cnt, comparisons, cycles;

  tcv_top dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out),
    .b_oe(b_oe), .a_capture_clock(a_cap), .b_capture_clock(b_cap));

  tcv_bus_model bus (.mclk(mclk), .a_out(a_out), .a_oe(a_oe),
    .b_out(b_out), .b_oe(b_oe), .a_drv(a_drv), .a_drv_en(a_drv_en),
    .b_drv(b_drv), .b_drv_en(b_drv_en), .a_in(a_in), .b_in(b_in));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      $display("unexpected at %0t: run hung", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus_write(input logic [4:0] addr, input logic [31:0] d);
    avs_address <= addr;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic read_chk(input logic [4:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    avs_address <= addr;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    check(d, exp);
    @(posedge mclk);
  endtask

  task automatic drive(input logic [15:0] av, input logic [1:0] ae,
                       input logic [15:0] bv, input logic [1:0] be);
    a_drv <= av;
    a_drv_en <= ae;
    b_drv <= bv;
    b_drv_en <= be;
  endtask

  task automatic capture(input logic [1:0] a, input logic [1:0] b);
    a_cap <= a;
    b_cap <= b;
    tick(2);
    a_cap <= 2'h0;
    b_cap <= 2'h0;
    tick(2);
  endtask

  function automatic logic [15:0] lanes(input logic [1:0] oe);
    return {{8{oe[1]}}, {8{oe[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    a_cap = 2'h0;
    b_cap = 2'h0;
    a_drv = 16'h0;
    b_drv = 16'h0;
    a_drv_en = 2'h3;
    b_drv_en = 2'h3;
    tick(4);
    arst_n <= 1'b1;
    tick(1);
    check(32'({a_oe, b_oe}), 32'h0);
    read_chk(tcv_pkg::OFF_CTRL, 32'h0000000c);
    read_chk(tcv_pkg::OFF_STATUS, 32'h0);
    read_chk(5'h18, 32'h0);
    $display("test reset done");

    // Five captures into a four-deep log: the last one overflows
    for (int i = 0; i < 5; i++) begin
      drive(16'h1100 + 16'(i), 2'h3, 16'h2200 + 16'(i), 2'h3);
      capture(2'h3, 2'h3);
    end
    read_chk(tcv_pkg::OFF_STATUS, 32'h3);
    for (int i = 0; i < 4; i++) begin
      read_chk(tcv_pkg::OFF_LOG, {16'h2200 + 16'(i), 16'h1100 + 16'(i)});
    end
    bus_write(tcv_pkg::OFF_STATUS, 32'h2);
    read_chk(tcv_pkg::OFF_STATUS, 32'h0);
    // Software capture into an empty log, then drain it again
    drive(16'h7788, 2'h3, 16'h99aa, 2'h3);
    bus_write(tcv_pkg::OFF_CAPTURE, 32'hf);
    read_chk(tcv_pkg::OFF_STORE, 32'h99aa7788);
    read_chk(tcv_pkg::OFF_LOG, 32'h99aa7788);
    $display("test log done");

    foreach (ROWS[i]) begin
      bus_write(tcv_pkg::OFF_CTRL, 32'h0c);
      tick(2);
      drive(ROWS[i].a_v, ~ROWS[i].a_oe, ROWS[i].b_v, ~ROWS[i].b_oe);
      bus_write(tcv_pkg::OFF_CTRL, 32'(ROWS[i].ctrl));
      tick(3);
      check(32'({a_oe, b_oe}), 32'({ROWS[i].a_oe, ROWS[i].b_oe}));
      check(32'(b_out & lanes(b_oe)), 32'(ROWS[i].a_v & lanes(b_oe)));
      check(32'(a_out & lanes(a_oe)), 32'(ROWS[i].b_v & lanes(a_oe)));
    end
    $display("test live rows done");

    bus_write(tcv_pkg::OFF_CTRL, 32'h0c);
    tick(2);
    drive(16'h1234, 2'h3, 16'h5678, 2'h3);
    capture(2'h3, 2'h3);
    read_chk(tcv_pkg::OFF_STORE, 32'h56781234);
    check(32'({a_oe, b_oe}), 32'h0);
    $display("test isolation done");

    bus_write(tcv_pkg::OFF_CTRL, 32'h3f);
    tick(3);
    check(32'(b_out), 32'h1234);
    drive(16'h9abc, 2'h3, 16'h0, 2'h0);
    capture(2'h3, 2'h0);
    check(32'(b_out), 32'h9abc);
    drive(16'h0, 2'h0, 16'h0, 2'h0);
    bus_write(tcv_pkg::OFF_CTRL, 32'hc0);
    tick(3);
    check(32'(a_out), 32'h5678);
    drive(16'h0, 2'h0, 16'hdef0, 2'h3);
    capture(2'h0, 2'h3);
    check(32'(a_out), 32'hdef0);
    drive(16'h0, 2'h0, 16'h0, 2'h0);
    bus_write(tcv_pkg::OFF_CTRL, 32'hf3);
    tick(3);
    check(32'({a_out, b_out}), 32'hdef09abc);
    $display("test stored done");

    bus_write(tcv_pkg::OFF_CTRL, 32'h0c);
    tick(2);
    drive(16'h4321, 2'h3, 16'h0, 2'h0);
    bus_write(tcv_pkg::OFF_CTRL, 32'h0f);
    tick(3);
    capture(2'h3, 2'h3);
    read_chk(tcv_pkg::OFF_STORE, 32'h43214321);
    // Both live directions with nobody else driving: the loop holds
    bus_write(tcv_pkg::OFF_CTRL, 32'h03);
    drive(16'h0, 2'h0, 16'h0, 2'h0);
    tick(3);
    check(32'({a_out, b_out}), 32'h43214321);
    $display("test both registers done");
    stop_test();
  end
endmodule

`default_nettype wire
